// ==== ums_defines.vh ====
/*
 Register offsets, field positions and reset values for the line and modem
 status block. Assumes inclusion by bare name from the block's module.
*/
`ifndef UMS_DEFINES_VH
`define UMS_DEFINES_VH

// Register offsets on the plain register port
`define UMS_ADDR_W 4
`define UMS_OFS_LINE_STATE 4'h5
`define UMS_OFS_MODEM_STATE 4'h6
`define UMS_OFS_MODEM_CTRL 4'h4
`define UMS_OFS_IRQ_STATUS 4'h8
`define UMS_OFS_IRQ_MASK 4'h9
`define UMS_OFS_RX_CTRL 4'hA
`define UMS_OFS_RX_DATA 4'h0

// Line status field positions
`define UMS_LS_READY 0
`define UMS_LS_OVERRUN 1
`define UMS_LS_PARITY 2

// Modem status field positions
`define UMS_MS_D_CTS 0
`define UMS_MS_D_DSR 1
`define UMS_MS_D_BELL 2
`define UMS_MS_D_CD 3
`define UMS_MS_CTS 4
`define UMS_MS_DSR 5
`define UMS_MS_BELL 6
`define UMS_MS_CD 7

// Modem control fields
`define UMS_MC_DTR 0
`define UMS_MC_RTS 1
`define UMS_MC_AUXA 2
`define UMS_MC_AUXB 3
`define UMS_MC_LOOP 4

// Interrupt status fields
`define UMS_IRQ_MODEM 0
`define UMS_IRQ_OVERRUN 1
`define UMS_IRQ_PARITY 2
`define UMS_IRQ_W 3

// Receive control fields
`define UMS_RC_FIFO_EN 0

// Receive FIFO shape
`define UMS_FIFO_DEPTH 16
`define UMS_PTR_W 4
`define UMS_CNT_W 5

// Reset values
`define UMS_RST_BYTE 8'h00
`define UMS_RST_IRQ 3'h0
`define UMS_RST_PTR 4'h0
`define UMS_RST_CNT 5'h00
`define UMS_RST_SYNC 4'hF
`define UMS_RST_NIB 4'h0
`define UMS_RST_CTRL 5'h00
`define UMS_RST_EFS 3'h0

// Feature select shape and FIFO word layout
`define UMS_EFS_W 3
`define UMS_EFS_LVL 0
`define UMS_FIFO_PAR 8

`endif

// ==== ums_status.v ====
/*
 Line status low bits and modem status register of one serial port, with a
 small receive FIFO that holds each character with its parity flag.
 Assumes one core clock, asynchronous active-high reset, a receiver that
 pulses rx_done with rx_char and rx_parity_bad, and modem pins that are
 asynchronous and active low.
*/
`timescale 1ns/10ps
`include "ums_defines.vh"

// Notes on behaviour
// [R1] Line bit 2 set when the character's parity fails, else zero.
// [R2] In FIFO mode parity flag belongs to the character at FIFO head.
// [R3] Line bit 1 set when a character completes while FIFO is full.
// [R4] On overrun the new character overwrites the shift register content.
// [R5] On overrun the full FIFO is not written; its contents stay intact.
// [R6] Line bit 0 high while any received character waits, else low.
// [R7] Modem status is read-only, showing the present handshake input state.
// [R8] Modem status address reads status; writes go to extra feature select.
// [R9] Change bits 3, 1, 0 set when their modem input changes; bell bit 2 per [R11].
// [R10] Every read of modem status clears all four change bits.
// [R11] Bell change bit 2 sets only on input going low to high.
// [R12] Modem interrupt raised while any of modem status bits 3:0 is one.
// [R13] Bit 7: inverse carrier detect, or aux output B in loopback.
// [R14] Bit 6: inverse bell sense, or aux output A in loopback.
// [R15] Bit 5: inverse data set ready, or terminal ready in loopback.
// [R16] Bit 4: inverse clear to send, or send request in loopback.
// [R17] Bits 3, 1, 0 flag changes on carrier, data set ready, clear to send.
// [R18] Inputs synchronised first; a change during a clearing read stays set.
module ums_status (
	input wire core_clk,
	input wire rst,
	input wire [`UMS_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire rx_done,
	input wire [7:0] rx_char,
	input wire rx_parity_bad,
	input wire clear_to_send_n,
	input wire data_set_ready_n,
	input wire bell_sense_in_n,
	input wire carrier_detect_in_n,
	output reg irq,
	output reg [2:0] extra_feature_select,
	output reg lvl_count_en,
	output reg [4:0] modem_ctrl_out
);

	// Software visible registers
	reg [7:0] modem_ctrl_reg_r;
	reg [7:0] rx_ctrl_r;
	reg [2:0] irq_status_r;
	reg [2:0] irq_mask_r;
	reg [3:0] modem_delta_r;

	// Receive path: shift register, holding register, overrun flag
	reg overrun_r;
	reg [7:0] shift_char_r;
	reg shift_par_r;
	reg [7:0] hold_char_r;
	reg hold_par_r;
	reg hold_full_r;

	// Receive FIFO: parity flag above each character
	reg [8:0] fifo_mem [0:`UMS_FIFO_DEPTH-1];
	reg [`UMS_PTR_W-1:0] wr_ptr_r;
	reg [`UMS_PTR_W-1:0] rd_ptr_r;
	reg [`UMS_CNT_W-1:0] count_r;

	// Modem pin synchronisers and change history
	reg [3:0] sync1_r;
	reg [3:0] sync2_r;
	reg [3:0] prev_r;

	// Mode bits and FIFO level
	wire fifo_en;
	wire loopback;
	wire fifo_full;
	wire fifo_empty;

	// Head of receive storage
	wire data_ready;
	wire [8:0] head_word;
	wire parity_fifo;
	wire parity_hold;
	wire parity_head;

	// Handshake line state and change detection
	wire [3:0] pin_level;
	wire [3:0] loop_level;
	wire [3:0] state_now;
	wire [3:0] change;

	// Decoded strobes
	wire rd_modem;
	wire rd_data;
	wire rd_line;
	wire wr_modem_ctrl;
	wire wr_rx_ctrl;
	wire wr_irq_mask;
	wire wr_irq_status;
	wire wr_feature;

	// Receive events
	wire overrun_ev;
	wire push;
	wire pop;

	// Register views and interrupt status
	wire [7:0] line_state;
	wire [7:0] modem_state;
	wire [2:0] irq_events;
	wire [2:0] irq_status_nxt;
	reg [7:0] rdata_nxt;

	// Mode bits and FIFO level
	assign fifo_en = rx_ctrl_r[`UMS_RC_FIFO_EN];
	assign loopback = modem_ctrl_reg_r[`UMS_MC_LOOP];
	assign fifo_full = (count_r == `UMS_FIFO_DEPTH);
	assign fifo_empty = (count_r == `UMS_RST_CNT);

	// Receive storage full test, per mode
	assign overrun_ev = rx_done & (fifo_en ? fifo_full : hold_full_r); // [R3]
	assign push = rx_done & ~overrun_ev & fifo_en; // [R5]
	assign rd_data = reg_rd & (reg_addr == `UMS_OFS_RX_DATA);
	assign pop = rd_data & fifo_en & ~fifo_empty;
	assign rd_modem = reg_rd & (reg_addr == `UMS_OFS_MODEM_STATE);

	// Strobe decode, one wire per register access
	assign rd_line = reg_rd & (reg_addr == `UMS_OFS_LINE_STATE);
	assign wr_modem_ctrl = reg_wr & (reg_addr == `UMS_OFS_MODEM_CTRL);
	assign wr_rx_ctrl = reg_wr & (reg_addr == `UMS_OFS_RX_CTRL);
	assign wr_irq_mask = reg_wr & (reg_addr == `UMS_OFS_IRQ_MASK);
	assign wr_irq_status = reg_wr & (reg_addr == `UMS_OFS_IRQ_STATUS);
	assign wr_feature = reg_wr & (reg_addr == `UMS_OFS_MODEM_STATE); // [R8]

	// Ready and parity taken from the head of storage
	assign data_ready = fifo_en ? ~fifo_empty : hold_full_r; // [R6]

	// Word at the head of the FIFO, character with its parity flag
	assign head_word = fifo_mem[rd_ptr_r];
	assign parity_fifo = ~fifo_empty & head_word[`UMS_FIFO_PAR]; // [R2]
	assign parity_hold = hold_full_r & hold_par_r; // [R1]
	assign parity_head = fifo_en ? parity_fifo : parity_hold; // [R1] [R2]

	// Line status: parity at head, overrun, data ready
	assign line_state = {5'h00, parity_head, overrun_r, data_ready};

	// Present state of handshake lines, bit order cts, dsr, bell, cd
	assign pin_level = ~sync2_r;
	// Loopback view of the modem control bits
	assign loop_level[`UMS_MS_D_CTS] = modem_ctrl_reg_r[`UMS_MC_RTS]; // [R16]
	assign loop_level[`UMS_MS_D_DSR] = modem_ctrl_reg_r[`UMS_MC_DTR]; // [R15]
	assign loop_level[`UMS_MS_D_BELL] = modem_ctrl_reg_r[`UMS_MC_AUXA]; // [R14]
	assign loop_level[`UMS_MS_D_CD] = modem_ctrl_reg_r[`UMS_MC_AUXB]; // [R13]
	assign state_now = loopback ? loop_level : pin_level; // [R13] [R14] [R15] [R16]

	// Change detectors: both edges except bell, rising only
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_delta
			if (gi == 2) begin : g_bell
				assign change[gi] = ~state_now[gi] & prev_r[gi]; // [R11]
			end else begin : g_any
				assign change[gi] = state_now[gi] ^ prev_r[gi]; // [R9] [R17]
			end
		end
	endgenerate

	// Modem status view: line state above the change flags
	assign modem_state = {state_now, modem_delta_r}; // [R7]

	// Interrupt events: parity of a pushed character, overrun, any modem change
	assign irq_events = {rx_parity_bad & push, overrun_ev, |modem_delta_r}; // [R12]

	// Sticky status per bit: the event wins over a same-cycle write of one
	genvar gb;
	generate
		for (gb = 0; gb < `UMS_IRQ_W; gb = gb + 1) begin : g_irq
			assign irq_status_nxt[gb] = irq_events[gb] |
				(irq_status_r[gb] & ~(wr_irq_status & reg_wdata[gb]));
		end
	endgenerate

	// Two-flop synchronisers on the asynchronous modem pins
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1_r <= `UMS_RST_SYNC;
			sync2_r <= `UMS_RST_SYNC;
		end else begin
			sync1_r <= {carrier_detect_in_n, bell_sense_in_n, data_set_ready_n,
				clear_to_send_n}; // [R18]
			sync2_r <= sync1_r;
		end
	end

	// Last seen line state, compared by the change detectors
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prev_r <= `UMS_RST_NIB;
		end else begin
			prev_r <= state_now;
		end
	end

	// Change flags: a new change wins over the clearing read
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			modem_delta_r <= `UMS_RST_NIB;
		end else begin
			modem_delta_r <= (rd_modem ? 4'h0 : modem_delta_r) | change; // [R10] [R18]
		end
	end

	// Interrupt status, mask and the level interrupt output
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_status_r <= `UMS_RST_IRQ;
			irq_mask_r <= `UMS_RST_IRQ;
			irq <= 1'b0;
		end else begin
			irq_status_r <= irq_status_nxt;
			if (wr_irq_mask) begin
				irq_mask_r <= reg_wdata[`UMS_IRQ_W-1:0];
			end
			irq <= |(irq_status_nxt & irq_mask_r); // [R12]
		end
	end

	// Modem control and receive control registers
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			modem_ctrl_reg_r <= `UMS_RST_BYTE;
			rx_ctrl_r <= `UMS_RST_BYTE;
		end else begin
			if (wr_modem_ctrl) begin
				modem_ctrl_reg_r <= reg_wdata;
			end
			if (wr_rx_ctrl) begin
				rx_ctrl_r <= reg_wdata;
			end
		end
	end

	// Copy of modem control bits for the pins, one cycle behind
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			modem_ctrl_out <= `UMS_RST_CTRL;
		end else begin
			modem_ctrl_out <= modem_ctrl_reg_r[`UMS_MC_LOOP:0];
		end
	end

	// Writes at the modem status address land in the feature select
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			extra_feature_select <= `UMS_RST_EFS;
			lvl_count_en <= 1'b0;
		end else if (wr_feature) begin
			extra_feature_select <= reg_wdata[`UMS_EFS_W-1:0]; // [R8]
			lvl_count_en <= reg_wdata[`UMS_EFS_LVL];
		end
	end

	// Receive shift register: every arriving character overwrites it
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			shift_char_r <= `UMS_RST_BYTE;
			shift_par_r <= 1'b0;
		end else if (rx_done) begin
			shift_char_r <= rx_char; // [R4]
			shift_par_r <= rx_parity_bad; // [R4]
		end
	end

	// Holding register for the mode without FIFO
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hold_char_r <= `UMS_RST_BYTE;
			hold_par_r <= 1'b0;
			hold_full_r <= 1'b0;
		end else if (rx_done & ~overrun_ev & ~fifo_en) begin
			hold_char_r <= rx_char;
			hold_par_r <= rx_parity_bad; // [R1]
			hold_full_r <= 1'b1;
		end else if (rd_data & ~fifo_en) begin
			hold_full_r <= 1'b0;
		end
	end

	// Overrun flag: a new overrun wins over the clearing line read
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			overrun_r <= 1'b0;
		end else if (overrun_ev) begin
			overrun_r <= 1'b1; // [R3]
		end else if (rd_line) begin
			overrun_r <= 1'b0;
		end
	end

	// Receive FIFO pointers; clearing the enable flushes them
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= `UMS_RST_PTR;
			rd_ptr_r <= `UMS_RST_PTR;
		end else if (~fifo_en) begin
			wr_ptr_r <= `UMS_RST_PTR;
			rd_ptr_r <= `UMS_RST_PTR;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end

	// Receive FIFO fill count; full at the configured depth
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count_r <= `UMS_RST_CNT;
		end else if (~fifo_en) begin
			count_r <= `UMS_RST_CNT;
		end else if (push & ~pop) begin
			count_r <= count_r + 1'b1;
		end else if (pop & ~push) begin
			count_r <= count_r - 1'b1;
		end
	end

	// FIFO storage, character with its parity flag
	always @(posedge core_clk) begin
		if (push) begin
			fifo_mem[wr_ptr_r] <= {rx_parity_bad, rx_char}; // [R2] [R5]
		end
	end

	// Read data mux
	always @* begin
		case (reg_addr)
			`UMS_OFS_RX_DATA: begin
				rdata_nxt = fifo_en ? head_word[7:0] : hold_char_r;
			end
			`UMS_OFS_LINE_STATE: begin
				rdata_nxt = line_state; // [R1] [R3] [R6]
			end
			`UMS_OFS_MODEM_STATE: begin
				rdata_nxt = modem_state; // [R7] [R8]
			end
			`UMS_OFS_MODEM_CTRL: begin
				rdata_nxt = modem_ctrl_reg_r;
			end
			`UMS_OFS_RX_CTRL: begin
				rdata_nxt = rx_ctrl_r;
			end
			`UMS_OFS_IRQ_STATUS: begin
				rdata_nxt = {5'h00, irq_status_r};
			end
			`UMS_OFS_IRQ_MASK: begin
				rdata_nxt = {5'h00, irq_mask_r};
			end
			default: begin
				rdata_nxt = `UMS_RST_BYTE;
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= `UMS_RST_BYTE;
		end else begin
			reg_rdata <= reg_rd ? rdata_nxt : `UMS_RST_BYTE;
		end
	end

endmodule

// ==== ums_modem_model.sv ====
/*
 Modem side of the handshake pins: drives the four active-low pins.
 Assumes the bench chooses the wanted pin levels.
*/
`timescale 1ns/10ps
module ums_modem_model (
	input wire [3:0] want_n,
	output wire cts_n,
	output wire dsr_n,
	output wire bell_n,
	output wire cd_n
);
	// Pins settle shortly after the request, clear of the clock edge
	assign #3 {cd_n, bell_n, dsr_n, cts_n} = want_n;
endmodule

// ==== ums_status_asserts.sv ====
/*
 Port checker for the status block.
 Assumes it is bound into ums_status and sees only its ports.
*/
`timescale 1ns/10ps
module ums_status_asserts (
	input wire core_clk,
	input wire rst,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire clear_to_send_n,
	input wire data_set_ready_n,
	input wire bell_sense_in_n,
	input wire carrier_detect_in_n,
	input wire [2:0] extra_feature_select,
	input wire lvl_count_en,
	input wire [4:0] modem_ctrl_out
);
	wire [8:0] watch = {carrier_detect_in_n, bell_sense_in_n, data_set_ready_n,
		clear_to_send_n, modem_ctrl_out};
	wire [3:0] loop_view = {modem_ctrl_out[3], modem_ctrl_out[2], modem_ctrl_out[0],
		modem_ctrl_out[1]};
	reg [8:0] watch_r;
	reg [3:0] calm_r;
	wire calm = calm_r > 4'h6;
	wire rd_ms = reg_rd && reg_addr == 4'h6;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Counts cycles with pins and modem control held steady
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			watch_r <= 9'h1FF;
			calm_r <= 4'h0;
		end else begin
			watch_r <= watch;
			if (watch != watch_r)
				calm_r <= 4'h0;
			else if (calm_r != 4'hF)
				calm_r <= calm_r + 4'h1;
		end
	end
	// Modem status read while everything is settled
	sequence ms_read_s;
		calm && rd_ms;
	endsequence
	efs_write_a:
	assert property (reg_wr && reg_addr == 4'h6 |=> extra_feature_select == $past(reg_wdata[2:0]))
		else $error("feature select not loaded");
	lvl_en_a:
	assert property (reg_wr && reg_addr == 4'h6 |=> lvl_count_en == $past(reg_wdata[0]))
		else $error("level count enable not loaded");
	read_idle_a:
	assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without a read");
	ms_normal_a:
	assert property (ms_read_s ##0 !modem_ctrl_out[4] |=> reg_rdata[7:4] == ~$past(watch[8:5]))
		else $error("modem state not inverse of pins");
	ms_loop_a:
	assert property (ms_read_s ##0 modem_ctrl_out[4] |=> reg_rdata[7:4] == $past(loop_view))
		else $error("loopback state wrong");
	delta_clear_a:
	assert property (ms_read_s ##1 ms_read_s |=> reg_rdata[3:0] == 4'h0)
		else $error("change bits survive a read");
	ro_ctrl_a:
	assert property (calm && reg_wr && reg_addr == 4'h6 |=> ##1 $stable(modem_ctrl_out))
		else $error("modem status write changed control");
	irq_modem_a:
	assert property (ms_read_s ##1 (reg_rd && reg_addr == 4'h8 && reg_rdata[3:0] != 4'h0)
		|=> reg_rdata[0])
		else $error("modem interrupt status not set");
endmodule
bind ums_status ums_status_asserts ums_status_asserts_i (.*);

// ==== ums_status_tb_top.sv ====
/*
 Bench for the line and modem status block.
 Assumes the modem model and the checker are compiled first.
*/
`timescale 1ns/10ps
module ums_status_tb_top;
	reg core_clk = 1'b0;
	reg rst = 1'b1;
	reg [3:0] reg_addr = 4'h0;
	reg [7:0] reg_wdata = 8'h00;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg rx_done = 1'b0;
	reg [7:0] rx_char = 8'h00;
	reg rx_parity_bad = 1'b0;
	reg [3:0] pins_n = 4'hF;
	reg [7:0] got;
	reg [7:0] d1;
	wire [7:0] reg_rdata;
	wire cts_n, dsr_n, bell_n, cd_n, irq;
	integer fail_count = 0;
	integer checks_done = 0;
	integer i;
	// Device and modem side
	ums_status ums_status_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_done(rx_done), .rx_char(rx_char), .rx_parity_bad(rx_parity_bad),
		.clear_to_send_n(cts_n), .data_set_ready_n(dsr_n), .bell_sense_in_n(bell_n),
		.carrier_detect_in_n(cd_n), .irq(irq), .extra_feature_select(),
		.lvl_count_en(), .modem_ctrl_out());
	ums_modem_model ums_modem_model_i (.want_n(pins_n), .cts_n(cts_n), .dsr_n(dsr_n),
		.bell_n(bell_n), .cd_n(cd_n));
	// Clock and watchdog
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count = fail_count + 1;
		final_report;
	end
	// Shared helpers
	task chk(input [8*12-1:0] what, input [7:0] seen, input [7:0] exp);
	begin
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("mismatch %0s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	// Tasks start and end on a rising edge; read data is taken at the edge closing its cycle
	task idle(input integer n);
	begin
		repeat (n) @(posedge core_clk);
	end
	endtask
	task wr(input [3:0] a, input [7:0] d);
	begin
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	end
	endtask
	// One read, or two back to back; d1 keeps the first
	task rd(input [3:0] a, input two, output [7:0] d);
	begin
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		if (two) begin
			@(posedge core_clk);
			d1 = reg_rdata;
		end
		reg_rd <= 1'b0;
		@(posedge core_clk);
		d = reg_rdata;
	end
	endtask
	// Two reads back to back at different addresses: d1 then got
	task rd_pair(input [3:0] a, input [3:0] b);
	begin
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_addr <= b;
		@(posedge core_clk);
		d1 = reg_rdata;
		reg_rd <= 1'b0;
		@(posedge core_clk);
		got = reg_rdata;
	end
	endtask
	task rx(input [7:0] c, input p);
	begin
		rx_char <= c;
		rx_parity_bad <= p;
		rx_done <= 1'b1;
		@(posedge core_clk);
		rx_done <= 1'b0;
		@(posedge core_clk);
	end
	endtask
	task pin(input [3:0] v);
	begin
		pins_n <= v;
		idle(10);
		rd(4'h6, 1'b1, got);
	end
	endtask
	task final_report;
	begin
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	// Scenario: modem pin changes, clearing reads and interrupt
	task t_modem;
	begin
		rd(4'h6, 1'b0, got);
		chk("idle modem", got, 8'h00);
		wr(4'h9, 8'h01);
		pin(4'hE);
		chk("cts delta", d1, 8'h11);
		chk("cleared", got, 8'h10);
		chk("irq on", {7'h00, irq}, 8'h01);
		wr(4'h8, 8'h01);
		idle(2);
		chk("irq off", {7'h00, irq}, 8'h00);
		pin(4'hA);
		chk("bell fall", d1, 8'h50);
		pin(4'hE);
		chk("bell rise", d1, 8'h14);
		pin(4'h4);
		chk("cd dsr", d1, 8'hBA);
		pin(4'hF);
		chk("all back", d1, 8'h0B);
		pins_n <= 4'hE;
		idle(10);
		rd_pair(4'h6, 4'h8);
		chk("cts again", d1, 8'h11);
		chk("irq status", got, 8'h01);
		pin(4'hF);
	end
	endtask
	// Scenario: loopback views and writes at the modem status address
	task t_loop;
	begin
		wr(4'h4, 8'h15);
		idle(9);
		rd(4'h6, 1'b1, got);
		chk("loop dtr", got & 8'hF0, 8'h60);
		wr(4'h4, 8'h1A);
		idle(9);
		rd(4'h6, 1'b1, got);
		chk("loop rts", got & 8'hF0, 8'h90);
		wr(4'h4, 8'h00);
		idle(9);
		wr(4'h6, 8'h07);
		rd(4'h6, 1'b1, got);
		chk("ro modem", got, 8'h00);
		rd(4'hF, 1'b0, got);
		chk("unmapped", got, 8'h00);
	end
	endtask
	// Scenario: parity at FIFO head, then overrun on a full FIFO
	task t_line;
	begin
		wr(4'hA, 8'h01);
		rx(8'h41, 1'b1);
		rx(8'h42, 1'b0);
		rd(4'h5, 1'b0, got);
		chk("parity head", got, 8'h05);
		rd(4'h0, 1'b0, got);
		chk("first char", got, 8'h41);
		rd(4'h5, 1'b0, got);
		chk("parity next", got, 8'h01);
		for (i = 0; i < 16; i = i + 1) begin
			rx(8'h50 + i[7:0], 1'b0);
		end
		rd(4'h5, 1'b0, got);
		chk("overrun", got, 8'h03);
		rd(4'h0, 1'b0, got);
		chk("kept char", got, 8'h42);
		for (i = 0; i < 15; i = i + 1) begin
			rd(4'h0, 1'b0, got);
			chk("kept char", got, 8'h50 + i[7:0]);
		end
		rd(4'h5, 1'b0, got);
		chk("drained", got, 8'h00);
	end
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		t_modem;
		t_loop;
		t_line;
		final_report;
	end
endmodule
